// ==== common/ircs_pkg.sv ====
package ircs_pkg;

  localparam int          NUM_TERM_ADV   = 5;
  localparam int          NUM_TERM_STD   = 3;

  localparam logic [1:0]  SRC_KEYPAD     = 2'h0;
  localparam logic [1:0]  SRC_TERM_FR    = 2'h1;
  localparam logic [1:0]  SRC_TERM_RD    = 2'h2;
  localparam logic [1:0]  SRC_SERIAL     = 2'h3;
  localparam logic [1:0]  CMD_SOURCE_RST = 2'h1;

  localparam logic        DIR_FWD        = 1'h0;
  localparam logic        DIR_REV        = 1'h1;
  localparam logic        KEYPAD_DIR_RST = 1'h0;

  localparam logic [1:0]  PREVENT_NONE   = 2'h0;
  localparam logic [1:0]  PREVENT_FWD    = 2'h1;
  localparam logic [1:0]  PREVENT_REV    = 2'h2;
  localparam logic [1:0]  PREVENT_RST    = 2'h0;

  localparam logic        PON_RUN_RST    = 1'h0;
  localparam logic        RESTART_RST    = 1'h0;

  localparam logic [4:0]  FN_RUN         = 5'h00;
  localparam logic [4:0]  FN_DIR         = 5'h01;
  localparam logic [4:0]  FN_MAX         = 5'h1B;
  localparam logic [4:0]  TERM1_FN_RST   = 5'h00;
  localparam logic [4:0]  TERM2_FN_RST   = 5'h01;
  localparam logic [4:0]  TERM3_FN_RST   = 5'h02;
  localparam logic [4:0]  TERM4_FN_RST   = 5'h03;
  localparam logic [4:0]  TERM5_FN_RST   = 5'h04;

  localparam logic [7:0]  STATION_MIN    = 8'h01;
  localparam logic [7:0]  STATION_MAX    = 8'hFA;
  localparam logic [7:0]  STATION_RST    = 8'h01;
  localparam logic        PROTOCOL_RST   = 1'h0;
  localparam logic [2:0]  SPEED_MAX      = 3'h4;
  localparam logic [2:0]  SPEED_RST      = 3'h3;

  typedef logic [NUM_TERM_ADV-1:0][4:0] ircs_fn_array_t;

  typedef struct packed {
    logic [1:0]     cmd_source;
    logic           keypad_direction_sel;
    logic [1:0]     direction_prevent_sel;
    logic           power_on_run_en;
    logic           trip_reset_restart_en;
    ircs_fn_array_t terminal_function_sel;
    logic [7:0]     station_number;
    logic           protocol_sel;
    logic [2:0]     speed_sel;
  } ircs_cfg_t;

  typedef struct packed {
    logic run;
    logic reverse;
  } ircs_req_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RUN   = 2'b01,
    ST_DECEL = 2'b10
  } ircs_state_t;

  localparam ircs_cfg_t CFG_RST = '{
    cmd_source:            CMD_SOURCE_RST,
    keypad_direction_sel:  KEYPAD_DIR_RST,
    direction_prevent_sel: PREVENT_RST,
    power_on_run_en:       PON_RUN_RST,
    trip_reset_restart_en: RESTART_RST,
    terminal_function_sel: {TERM5_FN_RST, TERM4_FN_RST, TERM3_FN_RST,
                            TERM2_FN_RST, TERM1_FN_RST},
    station_number:        STATION_RST,
    protocol_sel:          PROTOCOL_RST,
    speed_sel:             SPEED_RST
  };

  function automatic logic dir_blocked(input logic [1:0] prevent,
                                       input logic       reverse);
    dir_blocked = (prevent == PREVENT_FWD && reverse == DIR_FWD) ||
                  (prevent == PREVENT_REV && reverse == DIR_REV);
  endfunction

  function automatic logic cfg_legal(input ircs_cfg_t c,
                                     input logic      adv);
    logic ok;
    ok = 1'b1;
    if (c.cmd_source == SRC_SERIAL && !adv)
      ok = 1'b0;
    if (c.direction_prevent_sel > PREVENT_REV)
      ok = 1'b0;
    for (int i = 0; i < NUM_TERM_ADV; i++) begin
      if (c.terminal_function_sel[i] > FN_MAX)
        ok = 1'b0;
    end
    if (c.station_number < STATION_MIN || c.station_number > STATION_MAX)
      ok = 1'b0;
    if (c.speed_sel > SPEED_MAX)
      ok = 1'b0;
    cfg_legal = ok;
  endfunction

endpackage

// ==== core/ircs_term_decode.sv ====
`timescale 1ns/10ps
`default_nettype none
module ircs_term_decode #(
  parameter int NUM_TERM = ircs_pkg::NUM_TERM_ADV
) (
  input  wire ircs_pkg::ircs_fn_array_t  terminal_function_sel,
  input  wire logic [4:0]                input_terminal,
  output var  ircs_pkg::ircs_req_t       fr_req,
  output var  ircs_pkg::ircs_req_t       rd_req
);

  logic run_role;
  logic dir_role;

  // Terminals beyond the fitted count are never looked at
  always_comb begin
    run_role = 1'b0;
    dir_role = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin // [R9]
      if (terminal_function_sel[i] == ircs_pkg::FN_RUN && input_terminal[i])
        run_role = 1'b1; // [R8]
      if (terminal_function_sel[i] == ircs_pkg::FN_DIR && input_terminal[i])
        dir_role = 1'b1; // [R8]
    end
  end

  // Both roles equal means stop in the forward/reverse encoding
  always_comb begin
    fr_req.run     = run_role ^ dir_role; // [R6] [R7]
    fr_req.reverse = dir_role & ~run_role; // [R6]
    rd_req.run     = run_role; // [R10]
    rd_req.reverse = dir_role; // [R10] [R11]
  end

endmodule
`default_nettype wire

// ==== core/ircs_run_select.sv ====
// Behaviour
// R1: Source 0: run key starts, stop key ends
// R2: Keypad stop decelerates before ending operation
// R3: Keypad direction applies only with source 0
// R4: Keypad direction stays writable in every source
// R5: Source selector takes 0..3, resets to 1
// R6: Source 1: fwd terminal forward, rev reverse
// R7: Source 1: both on or off means stop
// R8: Terminal functions 0..27; resets 0 and 1
// R9: Three terminals standard, five on advanced
// R10: Source 2: run terminal, forward when direction off
// R11: Source 2: direction terminal on runs reverse
// R12: Source 3 serial, advanced variant only
// R13: Station 1..250, protocol 0..1, speed 0..4
// R14: Prevention: 0 none, 1 forward, 2 reverse
// R15: Power-on run starts on present terminal run
// R16: Reset restart resumes if terminal run held
// R17: Restart on trip reset from terminal or keypad
// R18: Prohibited direction keeps motor stopped
// R19: Otherwise start only on fresh terminal edge
`timescale 1ns/10ps
`default_nettype none
module ircs_run_select #(
  parameter bit ADVANCED_IO = 1'b1
) (
  input  wire logic                  mclk,
  input  wire logic                  srst,
  input  wire logic                  cfg_wr,
  input  wire ircs_pkg::ircs_cfg_t   cfg_wdata,
  output var  ircs_pkg::ircs_cfg_t   cfg_q,
  output logic                       cfg_reject,
  input  wire logic                  power_ready,
  input  wire logic                  keypad_run_key,
  input  wire logic                  keypad_stop_key,
  input  wire logic [4:0]            input_terminal,
  input  wire logic                  trip_event,
  input  wire logic                  trip_reset_term,
  input  wire logic                  serial_valid,
  input  wire logic [7:0]            serial_station,
  input  wire logic                  serial_run,
  input  wire logic                  serial_reverse,
  input  wire logic                  motor_stopped,
  output logic                       run_fwd,
  output logic                       run_rev,
  output logic                       decel_active,
  output logic                       tripped
);

  localparam int NUM_TERM = ADVANCED_IO ? ircs_pkg::NUM_TERM_ADV
                                        : ircs_pkg::NUM_TERM_STD;

  ircs_pkg::ircs_state_t state_q;
  ircs_pkg::ircs_state_t next_state;
  ircs_pkg::ircs_req_t   fr_req;
  ircs_pkg::ircs_req_t   rd_req;
  ircs_pkg::ircs_req_t   term_req;
  ircs_pkg::ircs_req_t   want;
  logic                  next_rev;
  logic                  term_src;
  logic                  keypad_run_q;
  logic                  serial_run_q;
  logic                  serial_rev_q;
  logic                  power_q;
  logic                  power_rise;
  logic                  armed;
  logic                  trip_reset_pulse;
  logic                  blocked;
  logic                  start_ok;

  ircs_term_decode #(
    .NUM_TERM              (NUM_TERM)
  ) u_decode (
    .terminal_function_sel (cfg_q.terminal_function_sel),
    .input_terminal        (input_terminal),
    .fr_req                (fr_req),
    .rd_req                (rd_req)
  );

  // Settings are stored whatever the source is; illegal words are refused
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_q      <= ircs_pkg::CFG_RST; // [R5] [R8] [R13] [R14]
      cfg_reject <= 1'b0;
    end else begin
      cfg_reject <= 1'b0;
      if (cfg_wr) begin
        if (ircs_pkg::cfg_legal(cfg_wdata, ADVANCED_IO)) begin
          cfg_q <= cfg_wdata; // [R4] [R5] [R12] [R13] [R14]
        end else begin
          cfg_reject <= 1'b1; // [R12]
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      power_q <= 1'b0;
    end else begin
      power_q <= power_ready;
    end
  end

  assign power_rise = power_ready & ~power_q;

  // STOP/RST doubles as the keypad trip reset; a new trip wins over a reset
  assign trip_reset_pulse = tripped & ~trip_event &
                            (trip_reset_term | keypad_stop_key); // [R17]

  always_ff @(posedge mclk) begin
    if (srst) begin
      tripped <= 1'b0;
    end else if (trip_event) begin
      tripped <= 1'b1;
    end else if (trip_reset_pulse) begin
      tripped <= 1'b0; // [R17]
    end
  end

  // Stop has priority over run when both keys land in one cycle, for safety
  always_ff @(posedge mclk) begin
    if (srst) begin
      keypad_run_q <= 1'b0;
    end else if (tripped || cfg_q.cmd_source != ircs_pkg::SRC_KEYPAD) begin
      keypad_run_q <= 1'b0;
    end else if (keypad_stop_key) begin
      keypad_run_q <= 1'b0; // [R1] [R2]
    end else if (keypad_run_key) begin
      keypad_run_q <= 1'b1; // [R1]
    end
  end

  // Frames for another station are ignored
  always_ff @(posedge mclk) begin
    if (srst) begin
      serial_run_q <= 1'b0;
      serial_rev_q <= ircs_pkg::DIR_FWD;
    end else if (tripped || !ADVANCED_IO ||
                 cfg_q.cmd_source != ircs_pkg::SRC_SERIAL) begin
      serial_run_q <= 1'b0; // [R12]
      serial_rev_q <= ircs_pkg::DIR_FWD;
    end else if (serial_valid && serial_station == cfg_q.station_number) begin
      serial_run_q <= serial_run; // [R12] [R13]
      serial_rev_q <= serial_reverse;
    end
  end

  assign term_src = cfg_q.cmd_source == ircs_pkg::SRC_TERM_FR ||
                    cfg_q.cmd_source == ircs_pkg::SRC_TERM_RD;

  always_comb begin
    term_req = (cfg_q.cmd_source == ircs_pkg::SRC_TERM_FR) ? fr_req : rd_req;
    unique case (cfg_q.cmd_source)
      ircs_pkg::SRC_KEYPAD: begin
        want.run     = keypad_run_q; // [R1]
        want.reverse = cfg_q.keypad_direction_sel; // [R3]
      end
      ircs_pkg::SRC_TERM_FR,
      ircs_pkg::SRC_TERM_RD: begin
        want = term_req; // [R6] [R10] [R11]
      end
      ircs_pkg::SRC_SERIAL: begin
        want.run     = serial_run_q; // [R12]
        want.reverse = serial_rev_q;
      end
    endcase
  end

  // A terminal level is honoured only after it has been seen low, unless
  // power-on run or reset restart hand over the level already present
  always_ff @(posedge mclk) begin
    if (srst || !power_ready) begin
      armed <= 1'b0;
    end else if (power_rise) begin
      armed <= cfg_q.power_on_run_en & term_src; // [R15] [R19]
    end else if (trip_reset_pulse) begin
      armed <= cfg_q.trip_reset_restart_en & term_src; // [R16] [R17] [R19]
    end else if (tripped) begin
      armed <= 1'b0;
    end else if (!term_req.run) begin
      armed <= 1'b1; // [R19]
    end
  end

  assign blocked  = ircs_pkg::dir_blocked(cfg_q.direction_prevent_sel,
                                          want.reverse); // [R14]
  assign start_ok = power_q & ~tripped & want.run & ~blocked &
                    (armed | ~term_src); // [R18] [R19]

  // A trip drops the command at once; the output stage coasts the motor
  always_comb begin
    next_state = state_q;
    unique case (state_q)
      ircs_pkg::ST_IDLE: begin
        if (start_ok)
          next_state = ircs_pkg::ST_RUN;
      end
      ircs_pkg::ST_RUN: begin
        if (tripped || !power_q)
          next_state = ircs_pkg::ST_IDLE;
        else if (!want.run || blocked)
          next_state = ircs_pkg::ST_DECEL; // [R2] [R7] [R18]
      end
      ircs_pkg::ST_DECEL: begin
        if (tripped || !power_q || motor_stopped)
          next_state = ircs_pkg::ST_IDLE; // [R2]
        else if (start_ok)
          next_state = ircs_pkg::ST_RUN;
      end
      default: next_state = ircs_pkg::ST_IDLE;
    endcase
  end

  // Direction is frozen while ramping down
  always_comb begin
    unique case (next_state)
      ircs_pkg::ST_RUN:   next_rev = want.reverse; // [R3] [R6] [R11]
      ircs_pkg::ST_DECEL: next_rev = run_rev;
      default:            next_rev = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= ircs_pkg::ST_IDLE;
    end else begin
      state_q <= next_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      run_fwd      <= 1'b0;
      run_rev      <= 1'b0;
      decel_active <= 1'b0;
    end else begin
      run_fwd      <= (next_state != ircs_pkg::ST_IDLE) & ~next_rev;
      run_rev      <= (next_state != ircs_pkg::ST_IDLE) & next_rev;
      decel_active <= next_state == ircs_pkg::ST_DECEL; // [R2]
    end
  end

  a_cfg_reset_vals: assert property (@(posedge mclk) // [R5] [R8]
    $fell(srst) |-> cfg_q.cmd_source == 2'h1 &&
      cfg_q.terminal_function_sel[0] == 5'h00 &&
      cfg_q.terminal_function_sel[1] == 5'h01)
    else $error("selector reset values wrong");

  // Stop clears the run latch first, so the ramp shows one cycle later
  a_keypad_stop_decel: assert property (@(posedge mclk) // [R2]
    disable iff (srst)
    (cfg_q.cmd_source == ircs_pkg::SRC_KEYPAD && state_q == ircs_pkg::ST_RUN
     && keypad_stop_key && keypad_run_q && !tripped && !trip_event &&
     !blocked && power_q && power_ready && !cfg_wr)
    |=> ##1 decel_active && (run_fwd || run_rev))
    else $error("keypad stop did not decelerate");

  a_keypad_dir_use: assert property (@(posedge mclk) disable iff (srst) // [R3]
    (next_state == ircs_pkg::ST_RUN &&
     cfg_q.cmd_source == ircs_pkg::SRC_KEYPAD)
    |=> run_rev == $past(cfg_q.keypad_direction_sel))
    else $error("keypad direction not applied");

  a_fr_both_stop: assert property (@(posedge mclk) disable iff (srst) // [R7]
    (cfg_q.cmd_source == ircs_pkg::SRC_TERM_FR && state_q == ircs_pkg::ST_RUN
     && !tripped && power_q && !cfg_wr && fr_req.run == 1'b0)
    |=> state_q == ircs_pkg::ST_DECEL)
    else $error("equal fwd and rev terminals did not stop");

  a_fr_direction: assert property (@(posedge mclk) disable iff (srst) // [R6]
    (next_state == ircs_pkg::ST_RUN &&
     cfg_q.cmd_source == ircs_pkg::SRC_TERM_FR)
    |=> run_fwd == !$past(fr_req.reverse) && run_rev == $past(fr_req.reverse))
    else $error("fwd/rev terminal direction wrong");

  a_rd_reverse: assert property (@(posedge mclk) disable iff (srst) // [R11]
    (next_state == ircs_pkg::ST_RUN &&
     cfg_q.cmd_source == ircs_pkg::SRC_TERM_RD && rd_req.reverse)
    |=> run_rev && !run_fwd)
    else $error("direction terminal did not reverse");

  a_prevent_start: assert property (@(posedge mclk) disable iff (srst) // [R18]
    (state_q == ircs_pkg::ST_RUN && $past(state_q) != ircs_pkg::ST_RUN)
    |-> !ircs_pkg::dir_blocked($past(cfg_q.direction_prevent_sel), run_rev))
    else $error("started in a prohibited direction");

  a_serial_gate: assert property (@(posedge mclk) // [R12] [R13]
    disable iff (srst)
    $rose(serial_run_q) |-> ADVANCED_IO &&
      $past(serial_station) == $past(cfg_q.station_number))
    else $error("serial run taken from wrong station or variant");

  a_no_restart: assert property (@(posedge mclk) disable iff (srst) // [R19]
    (trip_reset_pulse && !cfg_q.trip_reset_restart_en && term_src)
    |=> ##1 state_q == ircs_pkg::ST_IDLE)
    else $error("restart without fresh terminal edge");

  a_reset_restart: assert property (@(posedge mclk) // [R16] [R17]
    disable iff (srst)
    (trip_reset_pulse && cfg_q.trip_reset_restart_en && term_src &&
     power_q && power_ready && !cfg_wr)
    ##1 (start_ok && !trip_event) |=> state_q == ircs_pkg::ST_RUN)
    else $error("reset restart did not resume");

  a_power_on_run: assert property (@(posedge mclk) // [R15] [R19]
    disable iff (srst)
    (power_rise && !cfg_q.power_on_run_en) |=> !armed)
    else $error("armed at power-up without power-on run");

endmodule
`default_nettype wire

// ==== tb/ircs_far_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ircs_far_model #(
  parameter int STOP_CYC = 6
) (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       host_req,
  input  wire logic [7:0] host_station,
  input  wire logic       host_run,
  input  wire logic       host_rev,
  input  wire logic       run_fwd,
  input  wire logic       run_rev,
  input  wire logic       decel_active,
  output logic            serial_valid,
  output logic [7:0]      serial_station,
  output logic            serial_run,
  output logic            serial_reverse,
  output logic            motor_stopped
);
  int cnt;
  // Fields flip between frames so a stale frame is never read as valid
  always_ff @(posedge mclk) begin
    if (srst) begin
      serial_valid   <= 1'b0;
      serial_station <= 8'h00;
      serial_run     <= 1'b0;
      serial_reverse <= 1'b0;
    end else begin
      serial_valid <= host_req;
      if (host_req) begin
        serial_station <= host_station;
        serial_run     <= host_run;
        serial_reverse <= host_rev;
      end else begin
        serial_station <= ~serial_station;
        serial_run     <= ~serial_run;
        serial_reverse <= ~serial_reverse;
      end
    end
  end
  // Ramp takes several cycles, so stop is never instant
  always_ff @(posedge mclk) begin
    cnt <= decel_active ? cnt + 1 : 0;
  end
  assign motor_stopped = !(run_fwd || run_rev) || cnt >= STOP_CYC;
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic                mclk, srst, cfg_wr, cfg_reject, power_ready;
  ircs_pkg::ircs_cfg_t cfg_wdata, cfg_q, cfg, good;
  logic                keypad_run_key, keypad_stop_key;
  logic [4:0]          input_terminal;
  logic                trip_event, trip_reset_term, serial_valid;
  logic [7:0]          serial_station, host_station;
  logic                serial_run, serial_reverse, motor_stopped;
  logic                run_fwd, run_rev, decel_active, tripped;
  logic                host_req, host_run, host_rev;
  logic                cfg_reject_std, run_fwd_std;
  int                  failures = 0;
  int                  cmp_count = 0;

  ircs_run_select #(.ADVANCED_IO(1'b1)) dut (
    .mclk(mclk), .srst(srst), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .cfg_q(cfg_q), .cfg_reject(cfg_reject), .power_ready(power_ready),
    .keypad_run_key(keypad_run_key), .keypad_stop_key(keypad_stop_key),
    .input_terminal(input_terminal), .trip_event(trip_event),
    .trip_reset_term(trip_reset_term), .serial_valid(serial_valid),
    .serial_station(serial_station), .serial_run(serial_run),
    .serial_reverse(serial_reverse), .motor_stopped(motor_stopped),
    .run_fwd(run_fwd), .run_rev(run_rev), .decel_active(decel_active),
    .tripped(tripped));

  // Standard variant: three terminals and no serial source
  ircs_run_select #(.ADVANCED_IO(1'b0)) dut_std (
    .mclk(mclk), .srst(srst), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .cfg_q(), .cfg_reject(cfg_reject_std), .power_ready(power_ready),
    .keypad_run_key(keypad_run_key), .keypad_stop_key(keypad_stop_key),
    .input_terminal(input_terminal), .trip_event(trip_event),
    .trip_reset_term(trip_reset_term), .serial_valid(serial_valid),
    .serial_station(serial_station), .serial_run(serial_run),
    .serial_reverse(serial_reverse), .motor_stopped(motor_stopped),
    .run_fwd(run_fwd_std), .run_rev(), .decel_active(),
    .tripped());

  ircs_far_model #(.STOP_CYC(6)) far (
    .mclk(mclk), .srst(srst), .host_req(host_req),
    .host_station(host_station), .host_run(host_run), .host_rev(host_rev),
    .run_fwd(run_fwd), .run_rev(run_rev), .decel_active(decel_active),
    .serial_valid(serial_valid), .serial_station(serial_station),
    .serial_run(serial_run), .serial_reverse(serial_reverse),
    .motor_stopped(motor_stopped));

  task automatic chk(input string nm, input logic [63:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr(input logic er);
    @(posedge mclk);
    cfg_wr    <= 1'b1;
    cfg_wdata <= cfg;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    #1;
    chk("cfg_reject", cfg_reject, er);
    if (er) cfg = good;
    else good = cfg;
    chk("cfg_q", cfg_q, good);
  endtask

  task automatic outs(input logic f, r, d);
    #1;
    chk("run_fwd", run_fwd, f);
    chk("run_rev", run_rev, r);
    chk("decel_active", decel_active, d);
  endtask

  task automatic term(input logic [4:0] v, input int n);
    @(posedge mclk);
    input_terminal <= v;
    cyc(n);
  endtask

  // Bits: run key, stop key, terminal trip reset, trip event
  task automatic ev(input logic [3:0] v);
    @(posedge mclk);
    {keypad_run_key, keypad_stop_key, trip_reset_term, trip_event} <= v;
    @(posedge mclk);
    {keypad_run_key, keypad_stop_key, trip_reset_term, trip_event} <= 4'h0;
    cyc(4);
  endtask

  task automatic host(input logic [7:0] st, input logic r, v);
    @(posedge mclk);
    host_req     <= 1'b1;
    host_station <= st;
    host_run     <= r;
    host_rev     <= v;
    @(posedge mclk);
    host_req <= 1'b0;
    cyc(3);
  endtask

  task automatic pwr();
    @(posedge mclk);
    power_ready <= 1'b0;
    cyc(2);
    power_ready <= 1'b1;
    cyc(4);
  endtask

  task automatic src(input logic [1:0] s);
    cfg = ircs_pkg::CFG_RST;
    cfg.cmd_source = s;
    wr(1'b0);
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    cyc(5000);
    failures++;
    wrap_up();
  end

  initial begin
    {srst, cfg_wr, power_ready, keypad_run_key, keypad_stop_key} = 5'h10;
    {trip_event, trip_reset_term, host_req, host_run, host_rev} = 5'h00;
    input_terminal = 5'h00;
    host_station   = 8'h00;
    cfg            = ircs_pkg::CFG_RST;
    good           = cfg;
    cfg_wdata      = cfg;
    cyc(16);
    srst <= 1'b0;
    #1;
    chk("cfg_q", cfg_q, ircs_pkg::CFG_RST);
    chk("tripped", tripped, 1'b0);
    outs(1'b0, 1'b0, 1'b0);
    @(posedge mclk);
    power_ready <= 1'b1;
    cyc(3);
    $display("TEST reset done");
    cfg.direction_prevent_sel = 2'h3;
    wr(1'b1);
    cfg.terminal_function_sel[0] = 5'h1C;
    wr(1'b1);
    cfg.station_number = 8'h00;
    wr(1'b1);
    cfg.station_number = 8'hFB;
    wr(1'b1);
    cfg.speed_sel = 3'h5;
    wr(1'b1);
    cfg.station_number           = 8'hFA;
    cfg.speed_sel                = 3'h4;
    cfg.protocol_sel             = 1'b1;
    cfg.terminal_function_sel[4] = 5'h1B;
    wr(1'b0);
    src(2'h3);
    chk("cfg_reject_std", cfg_reject_std, 1'b1);
    src(2'h1);
    $display("TEST settings done");
    cfg.keypad_direction_sel = ircs_pkg::DIR_REV;
    wr(1'b0);
    term(5'h01, 3);
    outs(1'b1, 1'b0, 1'b0);
    term(5'h03, 3);
    outs(1'b1, 1'b0, 1'b1);
    cyc(10);
    outs(1'b0, 1'b0, 1'b0);
    term(5'h00, 3);
    term(5'h02, 3);
    outs(1'b0, 1'b1, 1'b0);
    term(5'h00, 3);
    outs(1'b0, 1'b1, 1'b1);
    cyc(10);
    $display("TEST fwd_rev done");
    cfg.direction_prevent_sel = ircs_pkg::PREVENT_FWD;
    wr(1'b0);
    term(5'h01, 3);
    outs(1'b0, 1'b0, 1'b0);
    term(5'h00, 3);
    term(5'h02, 3);
    outs(1'b0, 1'b1, 1'b0);
    cfg.direction_prevent_sel = ircs_pkg::PREVENT_REV;
    wr(1'b0);
    cyc(2);
    outs(1'b0, 1'b1, 1'b1);
    term(5'h00, 12);
    term(5'h01, 3);
    outs(1'b1, 1'b0, 1'b0);
    term(5'h00, 12);
    $display("TEST prevent done");
    src(2'h2);
    term(5'h01, 3);
    outs(1'b1, 1'b0, 1'b0);
    term(5'h00, 12);
    term(5'h02, 3);
    outs(1'b0, 1'b0, 1'b0);
    term(5'h03, 3);
    outs(1'b0, 1'b1, 1'b0);
    term(5'h00, 12);
    cfg.terminal_function_sel[0] = 5'h05;
    cfg.terminal_function_sel[4] = ircs_pkg::FN_RUN;
    wr(1'b0);
    term(5'h10, 3);
    outs(1'b1, 1'b0, 1'b0);
    chk("run_fwd_std", run_fwd_std, 1'b0);
    term(5'h00, 12);
    $display("TEST run_dir done");
    src(2'h0);
    cfg.keypad_direction_sel = ircs_pkg::DIR_REV;
    wr(1'b0);
    term(5'h01, 3);
    outs(1'b0, 1'b0, 1'b0);
    ev(4'h8);
    outs(1'b0, 1'b1, 1'b0);
    ev(4'h4);
    outs(1'b0, 1'b1, 1'b1);
    cyc(10);
    outs(1'b0, 1'b0, 1'b0);
    term(5'h00, 2);
    $display("TEST keypad done");
    src(2'h3);
    host(8'h01, 1'b1, 1'b0);
    outs(1'b1, 1'b0, 1'b0);
    host(8'h02, 1'b0, 1'b0);
    outs(1'b1, 1'b0, 1'b0);
    host(8'h01, 1'b0, 1'b0);
    outs(1'b1, 1'b0, 1'b1);
    cyc(10);
    $display("TEST serial done");
    src(2'h1);
    term(5'h01, 3);
    ev(4'h1);
    outs(1'b0, 1'b0, 1'b0);
    chk("tripped", tripped, 1'b1);
    ev(4'h2);
    outs(1'b0, 1'b0, 1'b0);
    chk("tripped", tripped, 1'b0);
    term(5'h00, 3);
    term(5'h01, 3);
    outs(1'b1, 1'b0, 1'b0);
    cfg.trip_reset_restart_en = 1'b1;
    wr(1'b0);
    ev(4'h1);
    ev(4'h4);
    outs(1'b1, 1'b0, 1'b0);
    chk("tripped", tripped, 1'b0);
    ev(4'h1);
    ev(4'h2);
    outs(1'b1, 1'b0, 1'b0);
    $display("TEST trip done");
    term(5'h00, 12);
    @(posedge mclk);
    power_ready <= 1'b0;
    term(5'h01, 3);
    power_ready <= 1'b1;
    cyc(4);
    outs(1'b0, 1'b0, 1'b0);
    cfg.power_on_run_en = 1'b1;
    wr(1'b0);
    pwr();
    outs(1'b1, 1'b0, 1'b0);
    $display("TEST power_on done");
    wrap_up();
  end
endmodule
`default_nettype wire
